// *** rtl/sdtb_ctrl.sv ***
// Controller end: turns user requests into pin commands.
// Assumes the user issues only commands legal for the bank states.
`timescale 1ns/1ps
module sdtb_ctrl (
	// Clock and reset
	input  wire logic                       mclk,
	input  wire logic                       rst_n,
	// User request
	input  wire logic                       req_valid,
	input  wire logic [3:0]                 req_cmd,
	input  wire logic [sdtb_pkg::ADDR_W-1:0] req_addr,
	input  wire logic                       req_gate,
	output logic                            req_ready,
	// Command pins
	sdtb_if.ctrl                            pins
);
	logic                        gate_r;
	logic                        cs_n_r;
	logic                        ready_r;
	logic [2:0]                  strobe_r;
	logic [sdtb_pkg::ADDR_W-1:0] addr_r;
	logic [sdtb_pkg::CNT_W-1:0]  wait_r;
	logic [sdtb_pkg::CNT_W-1:0]  wait_nxt;

	// Wake setup count, reloaded when the gate rises
	always_comb begin
		wait_nxt = wait_r;
		if (!gate_r && req_gate) begin
			wait_nxt = sdtb_pkg::CNT_W'(sdtb_pkg::WAKE_SETUP_CYC);
		end else if (wait_r != '0) begin
			wait_nxt = wait_r - 1'b1;
		end
	end

	// Drive pins; ready is registered so the output comes from a flop
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gate_r   <= 1'b1;
			cs_n_r   <= 1'b1;
			strobe_r <= 3'h7;
			addr_r   <= '0;
			wait_r   <= '0;
			ready_r  <= 1'b1;
		end else begin
			gate_r   <= req_gate;
			wait_r   <= wait_nxt;
			ready_r  <= (wait_nxt == '0) && req_gate;
			cs_n_r   <= 1'b1;
			strobe_r <= 3'h7;
			if (req_valid && ready_r) begin
				cs_n_r   <= req_cmd[3];
				strobe_r <= req_cmd[2:0];
				addr_r   <= req_addr;
			end
		end
	end

	// Requests wait out the wake setup time
	assign req_ready = ready_r;
	assign pins.clk_gate = gate_r;
	assign pins.cs_n     = cs_n_r;
	assign pins.ras_n    = strobe_r[2];
	assign pins.cas_n    = strobe_r[1];
	assign pins.we_n     = strobe_r[0];
	assign pins.addr     = addr_r;
endmodule

// *** rtl/sdtb_if.sv ***
// Command pins between the controller end and the memory end.
// Assumes a single clock shared by both ends.
`timescale 1ns/1ps
interface sdtb_if;
	logic        clk_gate;
	logic        cs_n;
	logic        ras_n;
	logic        cas_n;
	logic        we_n;
	logic [11:0] addr;
	modport ctrl (output clk_gate, cs_n, ras_n, cas_n, we_n, addr);
	modport mem  (input clk_gate, cs_n, ras_n, cas_n, we_n, addr);
endinterface

// *** rtl/sdtb_mem.sv ***
// Memory end: clock-gate handling and two-bank command state tracking.
// Assumes pins are synchronous to mclk and driven by a well-behaved controller.
// Overview of operation
// - Low-power states exit on clock gate rise
// - Self-refresh recovery idles after row cycle
// - Recovery with gate falling enters power-down
// - Power-down exits to idle on gate rise
// - Normal state decodes strobes into commands
// - Self-refresh and power-down need idle banks
// - Gate fall in busy state suspends clock
// - Gate low previous cycle ends suspend next
// - Controller gives legal command at suspend
// - Controller waits wake setup after exit
// - Strobe encoding sampled every rising edge
// - Read targets selected bank, optional auto-close
// - Store targets bank; other burst goes active
// - Row open moves chosen idle bank active
// - Column uses low bits, ignores 8 and 9
// - Six bank states; refresh needs idle
`timescale 1ns/1ps
module sdtb_mem (
	// Clock and reset
	input  wire logic                       mclk,
	input  wire logic                       rst_n,
	// Command pins
	sdtb_if.mem                             pins,
	// Observed state
	output sdtb_pkg::sdtb_bank_e            bank0_state,
	output sdtb_pkg::sdtb_bank_e            bank1_state,
	output sdtb_pkg::sdtb_pwr_e             pwr_state,
	output logic [sdtb_pkg::ROW_W-1:0]      row_addr,
	output logic [sdtb_pkg::COL_W-1:0]      col_addr,
	output logic                            illegal_cmd,
	output logic                            mode_loaded,
	output logic [sdtb_pkg::ADDR_W-1:0]     mode_word,
	output logic                            refresh_pulse
);
	sdtb_pkg::sdtb_bank_e bank_r [2];
	sdtb_pkg::sdtb_bank_e bank_nxt [2];
	sdtb_pkg::sdtb_pwr_e  pwr_r;
	sdtb_pkg::sdtb_pwr_e  pwr_nxt;
	logic                 gate_prev_r;
	logic [sdtb_pkg::CNT_W-1:0] rc_cnt_r;
	logic [3:0]           cmd;
	logic                 sel;
	logic                 ac;
	logic                 gate;
	logic                 both_idle;
	logic                 run_cmd;
	logic                 illegal_nxt;

	// Command decode from strobes
	assign cmd  = {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n};
	assign sel  = pins.addr[sdtb_pkg::BANK_SEL_POS];
	assign ac   = pins.addr[sdtb_pkg::AUTOCLOSE_POS];
	assign gate = pins.clk_gate;
	assign both_idle = (bank_r[0] == sdtb_pkg::SDTB_IDLE) && (bank_r[1] == sdtb_pkg::SDTB_IDLE);
	// Commands change bank state only in normal state with gate high on both samples
	assign run_cmd = (pwr_r == sdtb_pkg::SDTB_NORMAL) && gate_prev_r && gate && !cmd[3];

	// Previous-cycle clock gate sample
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gate_prev_r <= 1'b1;
		end else begin
			gate_prev_r <= gate;
		end
	end

	// Power state transitions
	always_comb begin
		pwr_nxt = pwr_r;
		case (pwr_r)
			sdtb_pkg::SDTB_NORMAL: begin
				if (gate_prev_r && !gate) begin
					if (!both_idle) begin
						pwr_nxt = sdtb_pkg::SDTB_SUSPEND;
					end else if (!cmd[3] && cmd == sdtb_pkg::CMD_REFRESH) begin
						pwr_nxt = sdtb_pkg::SDTB_SELF_REF;
					end
				end else if (!gate_prev_r && both_idle) begin
					pwr_nxt = sdtb_pkg::SDTB_POWER_DOWN;
				end
			end
			sdtb_pkg::SDTB_SELF_REF: begin
				if (!gate_prev_r && gate) begin
					pwr_nxt = sdtb_pkg::SDTB_SR_RECOVER;
				end
			end
			sdtb_pkg::SDTB_SR_RECOVER: begin
				if (gate_prev_r && !gate) begin
					pwr_nxt = sdtb_pkg::SDTB_POWER_DOWN;
				end else if (gate && rc_cnt_r == '0) begin
					pwr_nxt = sdtb_pkg::SDTB_NORMAL;
				end
			end
			sdtb_pkg::SDTB_POWER_DOWN: begin
				if (!gate_prev_r && gate) begin
					pwr_nxt = sdtb_pkg::SDTB_NORMAL;
				end
			end
			sdtb_pkg::SDTB_SUSPEND: begin
				if (!gate_prev_r) begin
					pwr_nxt = sdtb_pkg::SDTB_NORMAL;
				end
			end
			default: pwr_nxt = sdtb_pkg::SDTB_NORMAL;
		endcase
	end

	// Power state register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pwr_r <= sdtb_pkg::SDTB_NORMAL;
		end else begin
			pwr_r <= pwr_nxt;
		end
	end

	// Row cycle counter for self-refresh recovery
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rc_cnt_r <= '0;
		end else if (pwr_r == sdtb_pkg::SDTB_SELF_REF) begin
			rc_cnt_r <= sdtb_pkg::CNT_W'(sdtb_pkg::ROW_CYCLE_CYC - 1);
		end else if (pwr_r == sdtb_pkg::SDTB_SR_RECOVER && rc_cnt_r != '0) begin
			rc_cnt_r <= rc_cnt_r - 1'b1;
		end
	end

	// Per-bank next state
	always_comb begin
		bank_nxt[0] = bank_r[0];
		bank_nxt[1] = bank_r[1];
		illegal_nxt = 1'b0;
		if (pwr_r == sdtb_pkg::SDTB_SR_RECOVER && gate && !cmd[3] && !cmd[2]) begin
			illegal_nxt = 1'b1;
		end
		if (pwr_r == sdtb_pkg::SDTB_SR_RECOVER && gate && !cmd[3] && cmd[2] && !cmd[1]) begin
			illegal_nxt = 1'b1;
		end
		if (run_cmd) begin
			case (cmd)
				sdtb_pkg::CMD_HALT: begin
					for (int b = 0; b < 2; b++) begin
						if (bank_r[b] != sdtb_pkg::SDTB_IDLE && bank_r[b] != sdtb_pkg::SDTB_ACTIVE) begin
							bank_nxt[b] = sdtb_pkg::SDTB_ACTIVE;
						end
					end
				end
				sdtb_pkg::CMD_READ, sdtb_pkg::CMD_STORE: begin
					if (bank_r[sel] == sdtb_pkg::SDTB_IDLE) begin
						illegal_nxt = 1'b1;
					end else begin
						if (cmd == sdtb_pkg::CMD_READ) begin
							bank_nxt[sel] = ac ? sdtb_pkg::SDTB_READ_AC : sdtb_pkg::SDTB_READ;
						end else begin
							bank_nxt[sel] = ac ? sdtb_pkg::SDTB_WRITE_AC : sdtb_pkg::SDTB_WRITE;
						end
						if (bank_r[!sel] != sdtb_pkg::SDTB_IDLE) begin
							bank_nxt[!sel] = sdtb_pkg::SDTB_ACTIVE;
						end
					end
				end
				sdtb_pkg::CMD_ROW_OPEN: begin
					if (bank_r[sel] == sdtb_pkg::SDTB_IDLE) begin
						bank_nxt[sel] = sdtb_pkg::SDTB_ACTIVE;
					end else begin
						illegal_nxt = 1'b1;
					end
				end
				sdtb_pkg::CMD_CLOSE: begin
					if (ac) begin
						bank_nxt[0] = sdtb_pkg::SDTB_IDLE;
						bank_nxt[1] = sdtb_pkg::SDTB_IDLE;
					end else begin
						bank_nxt[sel] = sdtb_pkg::SDTB_IDLE;
					end
				end
				sdtb_pkg::CMD_REFRESH, sdtb_pkg::CMD_MODE: begin
					illegal_nxt = !both_idle;
				end
				default: ;
			endcase
		end
	end

	// Bank state registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			bank_r[0] <= sdtb_pkg::SDTB_IDLE;
			bank_r[1] <= sdtb_pkg::SDTB_IDLE;
		end else begin
			bank_r[0] <= bank_nxt[0];
			bank_r[1] <= bank_nxt[1];
		end
	end

	// Registered address capture and event outputs
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			row_addr      <= '0;
			col_addr      <= '0;
			mode_word     <= '0;
			mode_loaded   <= 1'b0;
			refresh_pulse <= 1'b0;
			illegal_cmd   <= 1'b0;
		end else begin
			mode_loaded   <= 1'b0;
			refresh_pulse <= 1'b0;
			illegal_cmd   <= illegal_nxt;
			if (run_cmd && cmd == sdtb_pkg::CMD_ROW_OPEN) begin
				row_addr <= pins.addr[sdtb_pkg::ROW_W-1:0];
			end
			if (run_cmd && (cmd == sdtb_pkg::CMD_READ || cmd == sdtb_pkg::CMD_STORE) && !illegal_nxt) begin
				col_addr <= pins.addr[sdtb_pkg::COL_W-1:0];
			end
			if (run_cmd && cmd == sdtb_pkg::CMD_MODE && both_idle) begin
				mode_word   <= pins.addr;
				mode_loaded <= 1'b1;
			end
			if (run_cmd && cmd == sdtb_pkg::CMD_REFRESH && both_idle) begin
				refresh_pulse <= 1'b1;
			end
		end
	end

	// State outputs
	assign bank0_state = bank_r[0];
	assign bank1_state = bank_r[1];
	assign pwr_state   = pwr_r;
endmodule

// *** rtl/sdtb_pkg.sv ***
// Shared constants and types for the two-bank DRAM command logic.
// Assumes both ends run on one clock, mclk, at 100 MHz.
package sdtb_pkg;
	// Command code: {cs_n, ras_n, cas_n, we_n} with cs_n low
	localparam logic [3:0] CMD_NOP      = 4'h7;
	localparam logic [3:0] CMD_HALT     = 4'h6;
	localparam logic [3:0] CMD_READ     = 4'h5;
	localparam logic [3:0] CMD_STORE    = 4'h4;
	localparam logic [3:0] CMD_ROW_OPEN = 4'h3;
	localparam logic [3:0] CMD_CLOSE    = 4'h2;
	localparam logic [3:0] CMD_REFRESH  = 4'h1;
	localparam logic [3:0] CMD_MODE     = 4'h0;
	// Address layout
	localparam int ADDR_W       = 12;
	localparam int BANK_SEL_POS = 11;
	localparam int AUTOCLOSE_POS = 10;
	localparam int COL_W        = 8;
	localparam int ROW_W        = 11;
	// Timing
	localparam int CLK_PERIOD_PS    = 10000;
	localparam int ROW_CYCLE_PS     = 70000;
	localparam int ROW_CYCLE_CYC    = (ROW_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WAKE_SETUP_PS    = 20000;
	localparam int WAKE_SETUP_CYC   = (WAKE_SETUP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W            = 8;
	// Per-bank state
	typedef enum logic [2:0] {
		SDTB_IDLE, SDTB_ACTIVE, SDTB_READ, SDTB_WRITE, SDTB_READ_AC, SDTB_WRITE_AC
	} sdtb_bank_e;
	// Device power state
	typedef enum logic [2:0] {
		SDTB_NORMAL, SDTB_SELF_REF, SDTB_SR_RECOVER, SDTB_POWER_DOWN, SDTB_SUSPEND
	} sdtb_pwr_e;
endpackage

// *** verif/sdtb_assertions.sv ***
// Concurrent checks on the command pins and the memory end's state outputs.
// Assumes the testbench instantiates this beside the interface, one clock mclk.
`timescale 1ns/1ps
module sdtb_assertions (
	// Clock and reset
	input wire logic                       mclk,
	input wire logic                       rst_n,
	// Command pins
	input wire logic                       clk_gate,
	input wire logic                       cs_n,
	input wire logic                       ras_n,
	input wire logic                       cas_n,
	input wire logic                       we_n,
	input wire logic [11:0]                addr,
	// Memory end state
	input wire sdtb_pkg::sdtb_bank_e       bank0_state,
	input wire sdtb_pkg::sdtb_bank_e       bank1_state,
	input wire sdtb_pkg::sdtb_pwr_e        pwr_state,
	input wire logic [10:0]                row_addr,
	input wire logic [7:0]                 col_addr,
	input wire logic                       illegal_cmd,
	input wire logic                       refresh_pulse
);
	logic       gate_prev_r;
	wire  [2:0] code  = {ras_n, cas_n, we_n};
	wire        idle0 = bank0_state == sdtb_pkg::SDTB_IDLE;
	wire        idle1 = bank1_state == sdtb_pkg::SDTB_IDLE;
	wire        norm  = pwr_state == sdtb_pkg::SDTB_NORMAL;
	wire        act   = norm && clk_gate && gate_prev_r && !cs_n;
	// Clock gate as seen one edge earlier
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			gate_prev_r <= 1'b1;
		end else begin
			gate_prev_r <= clk_gate;
		end
	end
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	a_row_open_idle: assert property (act && code == 3'h3 && !addr[11] && idle0 |=>
		bank0_state == sdtb_pkg::SDTB_ACTIVE && row_addr == $past(addr[10:0]) && bank1_state == $past(bank1_state))
		else $error("Row open did not activate bank 0");
	a_open_refused: assert property (act && code == 3'h3 && !addr[11] && !idle0 |=>
		bank0_state == $past(bank0_state) ##[0:1] illegal_cmd) else $error("Open of busy bank not refused");
	a_read_target: assert property (act && code == 3'h5 && !addr[11] && bank0_state == sdtb_pkg::SDTB_ACTIVE |=>
		bank0_state == ($past(addr[10]) ? sdtb_pkg::SDTB_READ_AC : sdtb_pkg::SDTB_READ) && col_addr == $past(addr[7:0]))
		else $error("Read state or column wrong");
	a_store_other: assert property (act && code == 3'h4 && addr[11] && !idle1 && bank0_state == sdtb_pkg::SDTB_READ
		|=> bank0_state == sdtb_pkg::SDTB_ACTIVE) else $error("Other bank kept bursting after store");
	a_halt_return: assert property (act && code == 3'h6 && bank1_state == sdtb_pkg::SDTB_WRITE |=>
		bank1_state == sdtb_pkg::SDTB_ACTIVE && bank0_state == $past(bank0_state)) else $error("Halt result wrong");
	a_close_all: assert property (act && code == 3'h2 && addr[10] |=> idle0 && idle1)
		else $error("Close all left a bank open");
	a_refresh_pulse: assert property (act && code == 3'h1 && idle0 && idle1 |-> ##[1:2] refresh_pulse)
		else $error("Refresh not reported");
	a_suspend_entry: assert property (norm && gate_prev_r && !clk_gate && !(idle0 && idle1) |=>
		pwr_state == sdtb_pkg::SDTB_SUSPEND) else $error("No suspend on gate fall");
	a_sref_entry: assert property (norm && gate_prev_r && !clk_gate && !cs_n && code == 3'h1 && idle0 && idle1 |=>
		pwr_state == sdtb_pkg::SDTB_SELF_REF) else $error("No self-refresh entry");
	a_sref_hold: assert property (pwr_state == sdtb_pkg::SDTB_SELF_REF && !clk_gate |=>
		pwr_state == sdtb_pkg::SDTB_SELF_REF) else $error("Self-refresh left while gate low");
	a_pd_exit: assert property (pwr_state == sdtb_pkg::SDTB_POWER_DOWN && !gate_prev_r && clk_gate |=> norm)
		else $error("Power-down not left on gate rise");
	a_recov_pd: assert property (pwr_state == sdtb_pkg::SDTB_SR_RECOVER && gate_prev_r && !clk_gate &&
		(cs_n || code == 3'h7) |=> pwr_state == sdtb_pkg::SDTB_POWER_DOWN) else $error("Recovery did not power down");
endmodule

// *** verif/testbench.sv ***
// Self-checking bench: controller end drives memory end through the interface.
// Assumes the package values for command codes and state encodings.
`timescale 1ns/1ps
module testbench;
	logic                   mclk      = 1'b0;
	logic                   rst_n     = 1'b0;
	logic                   req_valid = 1'b0;
	logic                   req_gate  = 1'b1;
	logic [3:0]             req_cmd   = 4'h7;
	logic [11:0]            req_addr  = 12'h000;
	logic                   req_ready;
	sdtb_pkg::sdtb_bank_e   bank0_state;
	sdtb_pkg::sdtb_bank_e   bank1_state;
	sdtb_pkg::sdtb_pwr_e    pwr_state;
	logic [10:0]            row_addr;
	logic [7:0]             col_addr;
	logic [11:0]            mode_word;
	logic                   illegal_cmd;
	logic                   mode_loaded;
	logic                   refresh_pulse;
	int                     num_errors  = 0;
	int                     check_count = 0;
	int                     ill_cnt     = 0;
	int                     ref_cnt     = 0;
	int                     mode_cnt    = 0;
	sdtb_if bus ();
	sdtb_ctrl sdtb_ctrl_i (.mclk(mclk), .rst_n(rst_n), .req_valid(req_valid), .req_cmd(req_cmd),
		.req_addr(req_addr), .req_gate(req_gate), .req_ready(req_ready), .pins(bus.ctrl));
	sdtb_mem sdtb_mem_i (.mclk(mclk), .rst_n(rst_n), .pins(bus.mem), .bank0_state(bank0_state),
		.bank1_state(bank1_state), .pwr_state(pwr_state), .row_addr(row_addr), .col_addr(col_addr),
		.illegal_cmd(illegal_cmd), .mode_loaded(mode_loaded), .mode_word(mode_word), .refresh_pulse(refresh_pulse));
	sdtb_assertions sdtb_assertions_i (.mclk(mclk), .rst_n(rst_n), .clk_gate(bus.clk_gate), .cs_n(bus.cs_n),
		.ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .addr(bus.addr), .bank0_state(bank0_state),
		.bank1_state(bank1_state), .pwr_state(pwr_state), .row_addr(row_addr), .col_addr(col_addr),
		.illegal_cmd(illegal_cmd), .refresh_pulse(refresh_pulse));
	// Clock
	always #5 mclk = ~mclk;
	// Count one-cycle pulses
	always @(posedge mclk) begin
		if (illegal_cmd === 1'b1) ill_cnt++;
		if (refresh_pulse === 1'b1) ref_cnt++;
		if (mode_loaded === 1'b1) mode_cnt++;
	end
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		if (num_errors == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// One request, pin image check, then settle
	task automatic issue(input logic [3:0] c, input logic [11:0] a, input logic g);
		int n = 0;
		req_gate = g;
		while (req_ready !== 1'b1 && n < 50) begin
			@(posedge mclk);
			#1;
			n++;
		end
		if (n == 50) begin
			num_errors++;
			finish_test();
		end
		req_valid = 1'b1;
		req_cmd = c;
		req_addr = a;
		@(posedge mclk);
		#1;
		req_valid = 1'b0;
		chk("pins", {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n, bus.addr}, {1'b0, c[2:0], a});
		@(posedge mclk);
		#1;
		chk("cs_n", bus.cs_n, 16'h0001);
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic gate(input logic g, input int n);
		req_gate = g;
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic st(input sdtb_pkg::sdtb_bank_e e0, input sdtb_pkg::sdtb_bank_e e1);
		chk("bank0_state", bank0_state, e0);
		chk("bank1_state", bank1_state, e1);
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge mclk);
		#1;
		rst_n = 1'b1;
		st(sdtb_pkg::SDTB_IDLE, sdtb_pkg::SDTB_IDLE);
		chk("pwr_state", pwr_state, sdtb_pkg::SDTB_NORMAL);
		issue(sdtb_pkg::CMD_NOP, 12'h000, 1'b1);
		issue(sdtb_pkg::CMD_ROW_OPEN, 12'h123, 1'b1);
		st(sdtb_pkg::SDTB_ACTIVE, sdtb_pkg::SDTB_IDLE);
		chk("row_addr", row_addr, 16'h0123);
		issue(sdtb_pkg::CMD_ROW_OPEN, 12'h123, 1'b1);
		chk("illegal", 16'(ill_cnt), 16'h0001);
		issue(sdtb_pkg::CMD_ROW_OPEN, 12'h8AB, 1'b1);
		st(sdtb_pkg::SDTB_ACTIVE, sdtb_pkg::SDTB_ACTIVE);
		issue(sdtb_pkg::CMD_READ, 12'h000, 1'b1);
		st(sdtb_pkg::SDTB_READ, sdtb_pkg::SDTB_ACTIVE);
		issue(sdtb_pkg::CMD_STORE, 12'h800, 1'b1);
		st(sdtb_pkg::SDTB_ACTIVE, sdtb_pkg::SDTB_WRITE);
		issue(sdtb_pkg::CMD_HALT, 12'h000, 1'b1);
		st(sdtb_pkg::SDTB_ACTIVE, sdtb_pkg::SDTB_ACTIVE);
		issue(sdtb_pkg::CMD_READ, 12'h7A5, 1'b1);
		st(sdtb_pkg::SDTB_READ_AC, sdtb_pkg::SDTB_ACTIVE);
		chk("col_addr", col_addr, 16'h00A5);
		issue(sdtb_pkg::CMD_REFRESH, 12'h000, 1'b1);
		chk("illegal", 16'(ill_cnt), 16'h0002);
		issue(sdtb_pkg::CMD_CLOSE, 12'h800, 1'b1);
		st(sdtb_pkg::SDTB_READ_AC, sdtb_pkg::SDTB_IDLE);
		issue(sdtb_pkg::CMD_CLOSE, 12'h400, 1'b1);
		st(sdtb_pkg::SDTB_IDLE, sdtb_pkg::SDTB_IDLE);
		issue(sdtb_pkg::CMD_REFRESH, 12'h000, 1'b1);
		chk("refresh", 16'(ref_cnt), 16'h0001);
		issue(sdtb_pkg::CMD_MODE, 12'h5A3, 1'b1);
		chk("mode_cnt", 16'(mode_cnt), 16'h0001);
		chk("mode_word", 16'(mode_word), 16'h05A3);
		issue(sdtb_pkg::CMD_ROW_OPEN, 12'h000, 1'b1);
		gate(1'b0, 2);
		chk("pwr_state", pwr_state, sdtb_pkg::SDTB_SUSPEND);
		gate(1'b0, 2);
		gate(1'b1, 4);
		chk("pwr_state", pwr_state, sdtb_pkg::SDTB_NORMAL);
		issue(sdtb_pkg::CMD_CLOSE, 12'h400, 1'b1);
		gate(1'b0, 6);
		chk("pwr_state", pwr_state, sdtb_pkg::SDTB_POWER_DOWN);
		gate(1'b1, 1);
		chk("req_ready", req_ready, 16'h0000);
		gate(1'b1, 2);
		chk("pwr_state", pwr_state, sdtb_pkg::SDTB_NORMAL);
		issue(sdtb_pkg::CMD_REFRESH, 12'h000, 1'b0);
		gate(1'b0, 4);
		chk("pwr_state", pwr_state, sdtb_pkg::SDTB_SELF_REF);
		gate(1'b1, 3);
		chk("pwr_state", pwr_state, sdtb_pkg::SDTB_SR_RECOVER);
		issue(sdtb_pkg::CMD_ROW_OPEN, 12'h000, 1'b1);
		chk("illegal", 16'(ill_cnt), 16'h0003);
		gate(1'b1, 8);
		chk("pwr_state", pwr_state, sdtb_pkg::SDTB_NORMAL);
		issue(sdtb_pkg::CMD_REFRESH, 12'h000, 1'b0);
		gate(1'b1, 3);
		gate(1'b0, 4);
		chk("pwr_state", pwr_state, sdtb_pkg::SDTB_POWER_DOWN);
		gate(1'b1, 4);
		chk("refresh", 16'(ref_cnt), 16'h0001);
		finish_test();
	end
endmodule
